// [hdl/smbrg_pkg.sv]
// Purpose: Shared constants and types for the SMBus EEPROM and I/O expander register bank.
// Assumes: 32-bit register words at byte addresses; one clock domain.
// Notes:   Every offset and bit position used by the design lives here, with the EEPROM and expander register reset values.
package smbrg_pkg;

  // Register byte offsets.
  localparam logic [11:0] SMBRG_EE_OFS      = 12'h0B4;
  localparam logic [11:0] SMBRG_IOX_OFS     = 12'h0B8;
  localparam logic [11:0] SMBRG_IRQ_STS_OFS = 12'h0C0;
  localparam logic [11:0] SMBRG_IRQ_EN_OFS  = 12'h0C4;
  localparam logic [11:0] SMBRG_IRQ_CLR_OFS = 12'h0C8;

  // EEPROM access control fields.
  localparam int SMBRG_EE_ADDR_LSB = 0;
  localparam int SMBRG_EE_ADDR_W   = 16;
  localparam int SMBRG_EE_DATA_LSB = 16;
  localparam int SMBRG_EE_DATA_W   = 8;
  localparam int SMBRG_EE_BUSY_BIT = 24;
  localparam int SMBRG_EE_DONE_BIT = 25;
  localparam int SMBRG_EE_KIND_BIT = 26;

  // I/O expander control fields.
  localparam int SMBRG_IOX_B_LSB      = 0;
  localparam int SMBRG_IOX_C_LSB      = 8;
  localparam int SMBRG_IOX_PORT_W     = 8;
  localparam int SMBRG_IOX_RELOAD_BIT = 24;
  localparam int SMBRG_IOX_TM_BIT     = 25;
  localparam int SMBRG_IOX_DONE_BIT   = 31;

  // Interrupt status, enable and clear layout.
  localparam int SMBRG_IRQ_EE_BIT  = 0;
  localparam int SMBRG_IRQ_IOX_BIT = 1;
  localparam int SMBRG_IRQ_W       = 2;

  // Reset values and EEPROM access kind encodings.
  localparam logic [31:0] SMBRG_EE_RST  = 32'h0000_0000;
  localparam logic [31:0] SMBRG_IOX_RST = 32'h0000_0000;
  localparam logic        SMBRG_EE_KIND_WRITE = 1'h0;
  localparam logic        SMBRG_EE_KIND_READ  = 1'h1;

  typedef enum logic {SMBRG_EE_IDLE, SMBRG_EE_WAIT} smbrg_ee_state_t;
  typedef enum logic {SMBRG_IOX_IDLE, SMBRG_IOX_WAIT} smbrg_iox_state_t;

endpackage : smbrg_pkg

// [hdl/smbrg_ee_seq.sv]
// Purpose: Tracks one EEPROM operation from launch to completion.
// Assumes: The engine answers each request with exactly one done pulse.
// Notes:   Busy is decoded from state so that it falls on the edge the done flag rises.
`timescale 1ns/1ps
module smbrg_ee_seq
  import smbrg_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       start,
  input  wire logic       eng_done,
  input  wire logic [7:0] eng_rdata,
  // Status.
  output logic            req,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdata
);

  smbrg_ee_state_t state_r;
  logic            req_r;
  logic [7:0]      rdata_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= SMBRG_EE_IDLE;
      req_r   <= 1'b0;
    end else begin
      case (state_r)
        SMBRG_EE_IDLE: begin
          req_r <= start;
          if (start) begin
            state_r <= SMBRG_EE_WAIT;
          end
        end
        SMBRG_EE_WAIT: begin
          req_r <= 1'b0;
          if (eng_done) begin
            state_r <= SMBRG_EE_IDLE;
          end
        end
        default: begin
          state_r <= SMBRG_EE_IDLE;
          req_r   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (state_r == SMBRG_EE_WAIT && eng_done) begin
      rdata_r <= eng_rdata;
    end
  end

  assign req   = req_r;
  assign busy  = (state_r == SMBRG_EE_WAIT);
  assign done  = (state_r == SMBRG_EE_WAIT) && eng_done;
  assign rdata = rdata_r;

endmodule : smbrg_ee_seq

// [hdl/smbrg_iox_seq.sv]
// Purpose: Launches expander transactions and queues one trigger that arrives mid-transaction.
// Assumes: The engine answers each request with exactly one done pulse.
// Notes:   Triggers during a transaction merge into a single follow-up transaction.
`timescale 1ns/1ps
module smbrg_iox_seq
  import smbrg_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Control.
  input  wire logic trig,
  input  wire logic eng_done,
  // Status.
  output logic      launch,
  output logic      req,
  output logic      done
);

  smbrg_iox_state_t state_r;
  logic             req_r;
  logic             pend_r;

  assign launch = (state_r == SMBRG_IOX_IDLE) && (trig || pend_r);
  assign done   = (state_r == SMBRG_IOX_WAIT) && eng_done;
  assign req    = req_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= SMBRG_IOX_IDLE;
      req_r   <= 1'b0;
      pend_r  <= 1'b0;
    end else begin
      case (state_r)
        SMBRG_IOX_IDLE: begin
          req_r  <= launch;
          pend_r <= 1'b0;
          if (launch) begin
            state_r <= SMBRG_IOX_WAIT;
          end
        end
        SMBRG_IOX_WAIT: begin
          req_r  <= 1'b0;
          pend_r <= pend_r || trig;
          if (eng_done) begin
            state_r <= SMBRG_IOX_IDLE;
          end
        end
        default: begin
          state_r <= SMBRG_IOX_IDLE;
          req_r   <= 1'b0;
          pend_r  <= 1'b0;
        end
      endcase
    end
  end

endmodule : smbrg_iox_seq

// [hdl/smbrg_regs.sv]
// Purpose: Register bank for master SMBus EEPROM access and I/O expander hot-plug signals.
// Assumes: A separate SMBus engine carries out each request and pulses done when finished.
// Notes:   Read data are registered and stand only in the cycle after the read strobe.
`timescale 1ns/1ps

module smbrg_regs
  import smbrg_pkg::*;
#(
  parameter int         ADDR_W    = 12,
  parameter logic [7:0] IN_MASK_B = 8'h0F,
  parameter logic [7:0] IN_MASK_C = 8'h0F
) (
  // Clock and reset.
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  // Register port.
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [31:0]       REG_RDATA,
  // Interrupt.
  output logic                   IRQ,
  // EEPROM engine.
  output logic                   EE_REQ,
  output logic                   EE_READ,
  output logic      [15:0]       EE_ADDR,
  output logic      [7:0]        EE_WDATA,
  input  wire logic              EE_DONE,
  input  wire logic [7:0]        EE_RDATA,
  // Expander engine.
  output logic                   IOX_REQ,
  output logic      [7:0]        IOX_OUT_B,
  output logic      [7:0]        IOX_OUT_C,
  input  wire logic              IOX_DONE,
  input  wire logic [7:0]        IOX_IN_B,
  input  wire logic [7:0]        IOX_IN_C,
  input  wire logic              IOX_ADDR_WR,
  // Core hot-plug outputs.
  input  wire logic [7:0]        HP_CORE_B,
  input  wire logic [7:0]        HP_CORE_C
);

  if (ADDR_W < 8 || ADDR_W > 12) begin : g_addr_check
    $error("ADDR_W must lie between 8 and 12 to reach every register offset.");
  end

  logic [11:0] addr_full;
  logic        wr_ee;
  logic        wr_iox;
  logic        wr_ien;
  logic        wr_iclr;

  logic [15:0] ee_addr_r;
  logic [7:0]  ee_data_r;
  logic        ee_kind_r;
  logic        ee_done_r;
  logic        ee_busy;
  logic        ee_done_p;
  logic        ee_start;
  logic [7:0]  ee_fetched;

  logic        tm_r;
  logic [15:0] sw_hp_r;
  logic [15:0] out_hp_r;
  logic [15:0] in_hp_r;
  logic [15:0] drv_hp;
  logic [15:0] rd_hp;
  logic [15:0] in_mask;
  logic        iox_trig;
  logic        iox_trig_r;
  logic        iox_launch;
  logic        iox_done_p;
  logic        iox_done_r;

  logic [SMBRG_IRQ_W-1:0] irq_sts_r;
  logic [SMBRG_IRQ_W-1:0] irq_en_r;
  logic [SMBRG_IRQ_W-1:0] irq_evt;

  logic [31:0] ee_word;
  logic [31:0] iox_word;
  logic [31:0] rdata_r;

  // Address decode.
  assign addr_full = 12'(REG_ADDR);
  assign wr_ee     = REG_WR && (addr_full == SMBRG_EE_OFS);
  assign wr_iox    = REG_WR && (addr_full == SMBRG_IOX_OFS);
  assign wr_ien    = REG_WR && (addr_full == SMBRG_IRQ_EN_OFS);
  assign wr_iclr   = REG_WR && (addr_full == SMBRG_IRQ_CLR_OFS);

  // A write during an operation only clears done; the launch fields stay put.
  assign ee_start = wr_ee && !ee_busy;

  smbrg_ee_seq u_ee_seq (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .start     (ee_start),
    .eng_done  (EE_DONE),
    .eng_rdata (EE_RDATA),
    .req       (EE_REQ),
    .busy      (ee_busy),
    .done      (ee_done_p),
    .rdata     (ee_fetched)
  );

  // EEPROM launch fields.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ee_addr_r <= SMBRG_EE_RST[SMBRG_EE_ADDR_LSB +: SMBRG_EE_ADDR_W];
      ee_kind_r <= SMBRG_EE_RST[SMBRG_EE_KIND_BIT];
    end else if (ee_start) begin
      ee_addr_r <= REG_WDATA[SMBRG_EE_ADDR_LSB +: SMBRG_EE_ADDR_W];
      ee_kind_r <= REG_WDATA[SMBRG_EE_KIND_BIT];
    end
  end

  // Data byte: written value for a write, fetched byte once a read completes.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ee_data_r <= SMBRG_EE_RST[SMBRG_EE_DATA_LSB +: SMBRG_EE_DATA_W];
    end else if (ee_start) begin
      ee_data_r <= REG_WDATA[SMBRG_EE_DATA_LSB +: SMBRG_EE_DATA_W];
    end else if (ee_done_p && ee_kind_r == SMBRG_EE_KIND_READ) begin
      ee_data_r <= EE_RDATA;
    end
  end

  // Done flag; a completion in the clearing cycle wins.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ee_done_r <= SMBRG_EE_RST[SMBRG_EE_DONE_BIT];
    end else if (ee_done_p) begin
      ee_done_r <= 1'b1;
    end else if (ee_start) begin
      ee_done_r <= 1'b0;
    end else if (wr_ee && REG_WDATA[SMBRG_EE_DONE_BIT]) begin
      ee_done_r <= 1'b0;
    end
  end

  assign EE_READ  = ee_kind_r;
  assign EE_ADDR  = ee_addr_r;
  assign EE_WDATA = ee_data_r;

  // Expander test mode.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tm_r <= SMBRG_IOX_RST[SMBRG_IOX_TM_BIT];
    end else if (wr_iox) begin
      tm_r <= REG_WDATA[SMBRG_IOX_TM_BIT];
    end
  end

  // Software hot-plug values are taken only while test mode is already set.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sw_hp_r <= SMBRG_IOX_RST[SMBRG_IOX_C_LSB + SMBRG_IOX_PORT_W - 1:SMBRG_IOX_B_LSB];
    end else if (wr_iox && tm_r) begin
      sw_hp_r <= REG_WDATA[SMBRG_IOX_C_LSB + SMBRG_IOX_PORT_W - 1:SMBRG_IOX_B_LSB];
    end
  end

  assign in_mask = {IN_MASK_C, IN_MASK_B};
  assign drv_hp  = tm_r ? sw_hp_r : {HP_CORE_C, HP_CORE_B};

  // Launch causes; delayed one cycle so a test-mode write is in sw_hp_r first.
  assign iox_trig = (wr_iox && REG_WDATA[SMBRG_IOX_RELOAD_BIT])
                 || (wr_iox && tm_r)
                 || IOX_ADDR_WR;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      iox_trig_r <= 1'b0;
    end else begin
      iox_trig_r <= iox_trig;
    end
  end

  smbrg_iox_seq u_iox_seq (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .trig     (iox_trig_r),
    .eng_done (IOX_DONE),
    .launch   (iox_launch),
    .req      (IOX_REQ),
    .done     (iox_done_p)
  );

  // Output values are frozen for the length of each transaction.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      out_hp_r <= SMBRG_IOX_RST[SMBRG_IOX_C_LSB + SMBRG_IOX_PORT_W - 1:SMBRG_IOX_B_LSB];
    end else if (iox_launch) begin
      out_hp_r <= drv_hp;
    end
  end

  // Input values are refreshed when the transaction completes.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      in_hp_r <= SMBRG_IOX_RST[SMBRG_IOX_C_LSB + SMBRG_IOX_PORT_W - 1:SMBRG_IOX_B_LSB];
    end else if (iox_done_p) begin
      in_hp_r <= {IOX_IN_C, IOX_IN_B};
    end
  end

  assign IOX_OUT_B = out_hp_r[SMBRG_IOX_B_LSB +: SMBRG_IOX_PORT_W];
  assign IOX_OUT_C = out_hp_r[SMBRG_IOX_C_LSB +: SMBRG_IOX_PORT_W];

  // Readback per bit: inputs never take software values.
  for (genvar i = 0; i < 16; i++) begin : g_hp_rd
    assign rd_hp[i] = in_mask[i] ? in_hp_r[i] : out_hp_r[i];
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      iox_done_r <= SMBRG_IOX_RST[SMBRG_IOX_DONE_BIT];
    end else if (iox_done_p) begin
      iox_done_r <= 1'b1;
    end else if (wr_iox && REG_WDATA[SMBRG_IOX_DONE_BIT]) begin
      iox_done_r <= 1'b0;
    end
  end

  // Interrupts: sticky status, enable, write-one clear; a new event wins.
  assign irq_evt[SMBRG_IRQ_EE_BIT]  = ee_done_p;
  assign irq_evt[SMBRG_IRQ_IOX_BIT] = iox_done_p;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      irq_sts_r <= '0;
    end else if (wr_iclr) begin
      irq_sts_r <= (irq_sts_r & ~REG_WDATA[SMBRG_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_sts_r <= irq_sts_r | irq_evt;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      irq_en_r <= '0;
    end else if (wr_ien) begin
      irq_en_r <= REG_WDATA[SMBRG_IRQ_W-1:0];
    end
  end

  assign IRQ = |(irq_sts_r & irq_en_r);

  // Read words; reserved bits and the reload bit are constant zero.
  always_comb begin
    ee_word = 32'h0000_0000;
    ee_word[SMBRG_EE_ADDR_LSB +: SMBRG_EE_ADDR_W] = ee_addr_r;
    ee_word[SMBRG_EE_DATA_LSB +: SMBRG_EE_DATA_W] = ee_data_r;
    ee_word[SMBRG_EE_BUSY_BIT] = ee_busy;
    ee_word[SMBRG_EE_DONE_BIT] = ee_done_r;
    ee_word[SMBRG_EE_KIND_BIT] = ee_kind_r;
  end

  always_comb begin
    iox_word = 32'h0000_0000;
    iox_word[SMBRG_IOX_C_LSB + SMBRG_IOX_PORT_W - 1:SMBRG_IOX_B_LSB] = rd_hp;
    iox_word[SMBRG_IOX_TM_BIT]   = tm_r;
    iox_word[SMBRG_IOX_DONE_BIT] = iox_done_r;
  end

  // Read data stand for one cycle only; unmapped offsets read zero.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rdata_r <= 32'h0000_0000;
    end else if (!REG_RD) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_full == SMBRG_EE_OFS) begin
      rdata_r <= ee_word;
    end else if (addr_full == SMBRG_IOX_OFS) begin
      rdata_r <= iox_word;
    end else if (addr_full == SMBRG_IRQ_STS_OFS) begin
      rdata_r <= {{(32 - SMBRG_IRQ_W){1'b0}}, irq_sts_r};
    end else if (addr_full == SMBRG_IRQ_EN_OFS) begin
      rdata_r <= {{(32 - SMBRG_IRQ_W){1'b0}}, irq_en_r};
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata_r;

endmodule : smbrg_regs

// [verif/smbrg_regs_asserts.sv]
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Helper flags follow open engine transactions and test mode.
`timescale 1ns/1ps
module smbrg_regs_asserts
  import smbrg_pkg::*;
#(
  parameter int         ADDR_W    = 12,
  parameter logic [7:0] IN_MASK_B = 8'h0F,
  parameter logic [7:0] IN_MASK_C = 8'h0F
) (
  input wire logic              REF_CLK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0]       REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [31:0]       REG_RDATA,
  input wire logic              IRQ,
  input wire logic              EE_REQ,
  input wire logic              EE_READ,
  input wire logic [15:0]       EE_ADDR,
  input wire logic              EE_DONE,
  input wire logic              IOX_REQ,
  input wire logic [7:0]        IOX_OUT_B,
  input wire logic              IOX_DONE,
  input wire logic [7:0]        HP_CORE_B
);
  logic ee_open_r;
  logic iox_open_r;
  logic tm_r;
  wire logic ee_busy = EE_REQ | ee_open_r;
  wire logic rd_ee = REG_RD && REG_ADDR == SMBRG_EE_OFS;
  wire logic rd_iox = REG_RD && REG_ADDR == SMBRG_IOX_OFS;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ee_open_r  <= 1'b0;
      iox_open_r <= 1'b0;
    end else begin
      ee_open_r  <= EE_REQ | (ee_open_r & ~EE_DONE);
      iox_open_r <= IOX_REQ | (iox_open_r & ~IOX_DONE);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tm_r <= 1'b0;
    end else if (REG_WR && REG_ADDR == SMBRG_IOX_OFS) begin
      tm_r <= REG_WDATA[25];
    end
  end

  AST_EE_LAUNCH: assert property (REG_WR && REG_ADDR == SMBRG_EE_OFS && !ee_busy
    |=> EE_REQ && EE_ADDR == $past(REG_WDATA[15:0]) && EE_READ == $past(REG_WDATA[26]))
    else $error("EEPROM launch does not follow the idle data write");
  AST_EE_ONE_OP: assert property (ee_open_r |-> !EE_REQ)
    else $error("EEPROM request while an operation is open");
  AST_EE_BUSY_RD: assert property (rd_ee |=> REG_RDATA[24] == $past(ee_busy)
    && !(REG_RDATA[24] && REG_RDATA[25]) && REG_RDATA[31:27] == 5'h00)
    else $error("EEPROM busy or done bit read back wrong");
  AST_EE_DONE_RD: assert property (rd_ee && $past(ee_open_r && EE_DONE) |=> REG_RDATA[25])
    else $error("EEPROM done bit not set after completion");
  AST_IOX_RELOAD: assert property (REG_WR && REG_ADDR == SMBRG_IOX_OFS && REG_WDATA[24]
    && !iox_open_r && !IOX_REQ |-> ##[1:2] IOX_REQ)
    else $error("Reload write did not launch an expander transaction");
  AST_IOX_CORE: assert property (IOX_REQ && !tm_r && !$past(tm_r)
    |-> ((IOX_OUT_B ^ $past(HP_CORE_B)) & ~IN_MASK_B) == 8'h00)
    else $error("Expander outputs differ from core values outside test mode");
  AST_IOX_HOLD: assert property (!IOX_REQ |-> $stable(IOX_OUT_B))
    else $error("Expander outputs changed without a transaction");
  AST_IOX_RD: assert property (rd_iox
    |=> REG_RDATA[24:16] == 9'h000 && REG_RDATA[30:26] == 5'h00)
    else $error("Expander reload or reserved bits read nonzero");
  AST_IOX_DONE_RD: assert property (rd_iox && $past(iox_open_r && IOX_DONE) |=> REG_RDATA[31])
    else $error("Expander done bit not set after completion");
  AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> $past(EE_DONE || IOX_DONE || REG_WR))
    else $error("Interrupt rose without a completion or a write");
endmodule : smbrg_regs_asserts

bind smbrg_regs smbrg_regs_asserts #(
  .ADDR_W(ADDR_W), .IN_MASK_B(IN_MASK_B), .IN_MASK_C(IN_MASK_C)
) u_asserts (
  .REF_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IRQ, .EE_REQ,
  .EE_READ, .EE_ADDR, .EE_DONE, .IOX_REQ, .IOX_OUT_B, .IOX_DONE, .HP_CORE_B
);

// [verif/smbrg_eng_model.sv]
// Purpose: Behavioural SMBus engine standing for the EEPROM and the I/O expander.
// Assumes: Requests are one-cycle pulses, one open transaction per side.
// Notes:   Data lines toggle outside the done cycle so stale values never look valid.
`timescale 1ns/1ps
module smbrg_eng_model (
  // Clock and pace.
  input  wire logic        clk,
  input  wire logic        slow,
  // EEPROM side.
  input  wire logic        ee_req,
  input  wire logic        ee_read,
  input  wire logic [15:0] ee_addr,
  output logic             ee_done = 1'b0,
  output logic      [7:0]  ee_rdata = 8'h3C,
  // Expander side.
  input  wire logic        iox_req,
  input  wire logic [7:0]  in_b,
  input  wire logic [7:0]  in_c,
  output logic             iox_done = 1'b0,
  output logic      [7:0]  iox_b = 8'hC3,
  output logic      [7:0]  iox_c = 8'h5A
);
  int ee_cnt = 0;
  int iox_cnt = 0;

  always @(posedge clk) begin
    ee_done  <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (ee_req) begin
      ee_cnt <= slow ? 9 : 2;
    end else if (ee_cnt == 1) begin
      ee_cnt   <= 0;
      ee_done  <= 1'b1;
      ee_rdata <= ee_read ? (ee_addr[7:0] ^ ee_addr[15:8]) : ee_rdata;
    end else if (ee_cnt > 1) begin
      ee_cnt <= ee_cnt - 1;
    end
  end

  always @(posedge clk) begin
    iox_done <= 1'b0;
    iox_b    <= ~iox_b;
    iox_c    <= ~iox_c;
    if (iox_req) begin
      iox_cnt <= slow ? 7 : 1;
    end else if (iox_cnt == 1) begin
      iox_cnt  <= 0;
      iox_done <= 1'b1;
      iox_b    <= in_b;
      iox_c    <= in_c;
    end else if (iox_cnt > 1) begin
      iox_cnt <= iox_cnt - 1;
    end
  end
endmodule : smbrg_eng_model

// [verif/smbrg_regs_tb.sv]
// Purpose: Self-checking bench for the SMBus register bank.
// Assumes: Input masks 0x0F on both ports; the engine model answers every request.
// Notes:   Status bits are polled with a bounded read loop.
`timescale 1ns/1ps
module smbrg_regs_tb
  import smbrg_pkg::*;
;
  localparam logic [7:0] MB = 8'h0F;
  localparam logic [7:0] MC = 8'h0F;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0, ax = 1'b0;
  logic        ee_req, ee_read, ee_done, iox_req, iox_done, irq, irq_s;
  logic [11:0] addr = 12'h000;
  logic [15:0] ee_addr, a;
  logic [31:0] wd = 32'h0, rdata, d, k, s;
  logic [7:0]  hb = 8'h00, hc = 8'h00, ib = 8'h00, ic = 8'h00;
  logic [7:0]  ee_rd, ee_wd, iib, iic, ob, oc, v;
  logic [11:0] offs [5] = '{12'h0B4, 12'h0B8, 12'h0C0, 12'h0C4, 12'h0BC};
  int          miscompares = 0, tests_run = 0, seed = 32'hca4c;

  always #5 clk = ~clk;

  smbrg_regs #(.ADDR_W(12), .IN_MASK_B(MB), .IN_MASK_C(MC)) dut (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq), .EE_REQ(ee_req), .EE_READ(ee_read),
    .EE_ADDR(ee_addr), .EE_WDATA(ee_wd), .EE_DONE(ee_done), .EE_RDATA(ee_rd),
    .IOX_REQ(iox_req), .IOX_OUT_B(ob), .IOX_OUT_C(oc), .IOX_DONE(iox_done),
    .IOX_IN_B(iib), .IOX_IN_C(iic), .IOX_ADDR_WR(ax), .HP_CORE_B(hb), .HP_CORE_C(hc));
  smbrg_eng_model u_eng (
    .clk(clk), .slow(slow), .ee_req(ee_req), .ee_read(ee_read), .ee_addr(ee_addr),
    .ee_done(ee_done), .ee_rdata(ee_rd), .iox_req(iox_req), .in_b(ib), .in_c(ic),
    .iox_done(iox_done), .iox_b(iib), .iox_c(iic));

  function automatic logic [7:0] mix(input logic [7:0] i, input logic [7:0] o,
                                     input logic [7:0] m);
    return (i & m) | (o & ~m);
  endfunction : mix

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr32(input logic [11:0] pa, input logic [31:0] pv);
    addr <= pa;
    wd   <= pv;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr32

  // Read data and the interrupt line are both taken in the cycle after the strobe.
  task automatic rd32(input logic [11:0] pa);
    addr <= pa;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d     = rdata;
    irq_s = irq;
    @(posedge clk);
  endtask : rd32

  task automatic poll(input logic [11:0] pa, input int b);
    int n;
    n = 0;
    rd32(pa);
    while (d[b] !== 1'b1 && n < 60) begin
      rd32(pa);
      n++;
    end
    if (n >= 60) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : poll

  initial begin
    #50000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (offs[i]) begin
      rd32(offs[i]);
      chk("reset_word", 32'h0, d);
    end
    for (int i = 0; i < 6; i++) begin
      k = $random(seed);
      // The first two passes are fixed corners: a fast read, then a slow write.
      if (i < 2) begin
        {k[31], k[26]} = {i[0], ~i[0]};
      end
      a = k[15:0];
      v = k[23:16];
      slow <= k[31];
      wr32(12'h0C4, {30'h0, i[0], i[0]});
      wr32(12'h0B4, {5'h00, k[26], 2'b11, v, a});
      rd32(12'h0B4);
      chk("ee_busy", 32'h1, {30'h0, d[25:24]});
      wr32(12'h0B4, ~d);
      poll(12'h0B4, 25);
      chk("ee_word", {5'h00, k[26], 2'b10, k[26] ? a[7:0] ^ a[15:8] : v, a}, d);
      chk("ee_addr", {16'h0, a}, {16'h0, ee_addr});
      chk("ee_wdata", {24'h0, k[26] ? a[7:0] ^ a[15:8] : v}, {24'h0, ee_wd});
      rd32(12'h0C0);
      chk("irq_sts", {30'h0, i[0], 1'b1}, {30'h0, irq_s, d[0]});
      wr32(12'h0C8, 32'h1);
      rd32(12'h0C0);
      chk("irq_clr", 32'h0, d | {31'h0, irq_s});
    end
    k = $random(seed);
    {hb, hc, ib, ic} <= k;
    slow <= 1'b1;
    wr32(12'h0B8, 32'h7DFF_FFFF);
    poll(12'h0B8, 31);
    chk("iox_core", {16'h8000, mix(ic, hc, MC), mix(ib, hb, MB)}, d);
    chk("iox_out", {16'h0, hc & ~MC, hb & ~MB}, {16'h0, oc & ~MC, ob & ~MB});
    rd32(12'h0C0);
    chk("irq_iox", 32'h6, {29'h0, irq_s, d[1:0]});
    wr32(12'h0B8, 32'h8000_0000);
    rd32(12'h0B8);
    chk("iox_w1c", 32'h0, {d[31], 31'h0});
    k = $random(seed);
    {ib, ic} <= k[15:0];
    slow <= 1'b0;
    ax <= 1'b1;
    @(posedge clk);
    ax <= 1'b0;
    poll(12'h0B8, 31);
    chk("iox_addr", {16'h8000, mix(ic, hc, MC), mix(ib, hb, MB)}, d);
    s = $random(seed);
    wr32(12'h0B8, {16'h8200, s[15:0]});
    rd32(12'h0B8);
    chk("tm_ignored", {16'h0200, mix(ic, hc, MC), mix(ib, hb, MB)}, d);
    hb <= ~hb;
    wr32(12'h0B8, {16'h0200, s[15:0]});
    poll(12'h0B8, 31);
    chk("tm_word", {16'h8200, mix(ic, s[15:8], MC), mix(ib, s[7:0], MB)}, d);
    chk("tm_out", {16'h0, s[15:8] & ~MC, s[7:0] & ~MB}, {16'h0, oc & ~MC, ob & ~MB});
    tally_and_finish();
  end
endmodule : smbrg_regs_tb
